// ==== hdl/ssm_defs.vh ====
// Constants for the spread spectrum modem parameter block
// Summary of operation
// - Modem select changes only while in Sleep
// - Modem owns a dual-port buffer over bus
// - Spread mode shows a different register map
// - Spread order 6..12 gives 64..4096 chips
// - Peers must share the same spread order
// - Ratio codes 1..4 give 4/5 to 4/8
// - Ratio may travel in the packet header
// - Bandwidth means total two-sided channel width
// - Ten bandwidth choices, 7.8 to 500 kHz
// - Symbol rate is bandwidth over 2^order
`ifndef SSM_DEFS_VH
`define SSM_DEFS_VH
// Register word addresses (byte offsets)
`define SSM_A_OPMODE     12'h000
`define SSM_A_SETUP1     12'h004
`define SSM_A_SETUP2     12'h008
`define SSM_A_TUNING     12'h00C
`define SSM_A_THRESH     12'h010
`define SSM_A_STATUS     12'h014
`define SSM_A_FSK_CFG    12'h018
`define SSM_A_BUF_PTR    12'h01C
`define SSM_A_BUF_DATA   12'h020
// Operating mode register fields
`define SSM_OP_MODE_LSB  0
`define SSM_OP_MODE_MSB  2
`define SSM_OP_SPREAD    7
`define SSM_MODE_SLEEP   3'h0
// Setup one: bandwidth [7:4], ratio [3:1], headerless [0]
`define SSM_BW_MSB       7
`define SSM_BW_LSB       4
`define SSM_CR_MSB       3
`define SSM_CR_LSB       1
`define SSM_IH_BIT       0
// Setup two: spread order [7:4]
`define SSM_SF_MSB       7
`define SSM_SF_LSB       4
// Limits and reset values
`define SSM_SF_MIN       4'h6
`define SSM_SF_MAX       4'hC
`define SSM_CR_MIN       3'h1
`define SSM_CR_MAX       3'h4
`define SSM_BW_MAX       4'h9
`define SSM_RST_SETUP1   8'h72
`define SSM_RST_SETUP2   8'h70
`define SSM_RST_TUNING   8'hC3
`define SSM_RST_THRESH   8'h0A
`define SSM_RST_FSK      8'h00
`define SSM_RST_OPMODE   8'h00
`define SSM_RST_ORDER    4'h7
`define SSM_RST_CR       3'h1
`define SSM_RST_BW       4'h7
`define SSM_RST_CHIPS    13'h0080
`define SSM_BUF_DEPTH    256
`endif

// ==== hdl/ssm_modem_params.v ====
// Spread spectrum modem mode selection, parameters and data buffer
`timescale 1ns/100ps
`include "ssm_defs.vh"
module ssm_modem_params
(
  input  wire        clk_sys,       // System clock, 200 MHz
  input  wire        reset,         // Synchronous reset, active high
  input  wire        psel,          // APB select
  input  wire        penable,       // APB access phase
  input  wire        pwrite,        // APB direction
  input  wire [11:0] paddr,         // APB byte address
  input  wire [31:0] pwdata,        // APB write data
  input  wire [3:0]  pstrb,         // APB byte strobes
  output reg  [31:0] prdata,        // APB read data
  output reg         pready,        // APB ready
  output reg         pslverr,       // APB error
  output reg         spread_mode,   // High while spread modem selected
  output reg  [3:0]  spread_order,  // Active spread order, 6..12
  output reg  [2:0]  fec_ratio_sel, // Active coding ratio code, 1..4
  output reg  [3:0]  bw_sel,        // Active bandwidth code, 0..9
  output reg         headerless,    // Implicit header mode
  output reg  [12:0] chips_per_sym  // 2^spread_order
);

  // All configuration lives in 8-bit registers on the low data lane.
  // The upper lanes read back as zero and are ignored on writes, so
  // software may use plain word accesses throughout.
  // Only byte strobe zero gates a write for the same reason.
  // Register state
  reg [7:0]  op_mode_r;             // Operating mode register
  reg [7:0]  setup1_r;              // Bandwidth, ratio, headerless
  reg [7:0]  setup2_r;              // Spread order
  reg [7:0]  tuning_r;              // Detect tuning register
  reg [7:0]  thresh_r;              // Detect threshold register
  reg [7:0]  fsk_cfg_r;             // Frequency-shift mode config
  reg [7:0]  buf_ptr_r;             // Buffer address pointer
  reg [7:0]  buf_mem [0:`SSM_BUF_DEPTH-1]; // Modem data buffer
  reg        bad_sf_r;              // Sticky: illegal order written
  reg        bad_mode_r;            // Sticky: refused modem switch

  // The slave answers with zero wait states, so the access phase is
  // always the last cycle of a transfer; pready only drops in reset.
  // A transfer therefore commits at the edge ending its access phase.
  // Access phase qualifiers
  wire acc  = psel & penable & pready;
  wire wr   = acc & pwrite & pstrb[0];
  wire rd   = acc & ~pwrite;
  wire in_sleep = (op_mode_r[`SSM_OP_MODE_MSB:`SSM_OP_MODE_LSB]
                   == `SSM_MODE_SLEEP);
  wire spr  = op_mode_r[`SSM_OP_SPREAD];

  // The decode is shared by the write path and the error response, so
  // it lives in one function; both sides then agree on what is hidden.
  // Mode and status stay visible in both modem choices.
  // Map check: spread-only registers hidden in frequency-shift mode
  function mapped;
    input [11:0] a;
    input        s;
    begin
      if (a == `SSM_A_OPMODE || a == `SSM_A_STATUS)
        mapped = 1'b1;
      else if (a == `SSM_A_FSK_CFG)
        mapped = ~s;
      else if (a == `SSM_A_SETUP1 || a == `SSM_A_SETUP2 ||
               a == `SSM_A_TUNING || a == `SSM_A_THRESH ||
               a == `SSM_A_BUF_PTR || a == `SSM_A_BUF_DATA)
        mapped = s;
      else
        mapped = 1'b0;
    end
  endfunction

  // Field views of the write data, checked before a register is
  // touched; a refused order, ratio or bandwidth leaves the old setting
  // whole, while a refused modem switch still takes the new mode field.
  wire hit = mapped(paddr, spr);
  wire [3:0] wsf = pwdata[`SSM_SF_MSB:`SSM_SF_LSB];
  wire [2:0] wcr = pwdata[`SSM_CR_MSB:`SSM_CR_LSB];
  wire [3:0] wbw = pwdata[`SSM_BW_MSB:`SSM_BW_LSB];
  wire sf_ok = (wsf >= `SSM_SF_MIN) && (wsf <= `SSM_SF_MAX);
  wire s1_ok = (wcr >= `SSM_CR_MIN) && (wcr <= `SSM_CR_MAX)
               && (wbw <= `SSM_BW_MAX);
  wire mode_chg = pwdata[`SSM_OP_SPREAD] != spr;

  // The modem choice bit may only move while the mode field reads
  // Sleep. A write that tries it at any other time still updates the
  // mode field, keeps the old choice and raises a sticky flag, so
  // software can see that its request was refused.
  // Sticky flags set and clear through different addresses, so a set
  // and a clear can never meet in one cycle.
  // Register writes; pready held high so every access ends in one cycle
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      op_mode_r  <= `SSM_RST_OPMODE;
      setup1_r   <= `SSM_RST_SETUP1;
      setup2_r   <= `SSM_RST_SETUP2;
      tuning_r   <= `SSM_RST_TUNING;
      thresh_r   <= `SSM_RST_THRESH;
      fsk_cfg_r  <= `SSM_RST_FSK;
      buf_ptr_r  <= 8'h00;
      bad_sf_r   <= 1'b0;
      bad_mode_r <= 1'b0;
    end
    else if (wr && hit)
    begin
      if (paddr == `SSM_A_OPMODE)
      begin
        // Switch modem only from Sleep, otherwise keep it
        if (mode_chg && !in_sleep)
        begin
          op_mode_r[`SSM_OP_MODE_MSB:`SSM_OP_MODE_LSB] <=
            pwdata[`SSM_OP_MODE_MSB:`SSM_OP_MODE_LSB];
          bad_mode_r <= 1'b1;
        end
        else
          op_mode_r <= pwdata[7:0];
      end
      else if (paddr == `SSM_A_SETUP1)
      begin
        // Out-of-range ratio or bandwidth codes are dropped whole
        if (s1_ok)
          setup1_r <= pwdata[7:0];
      end
      else if (paddr == `SSM_A_SETUP2)
      begin
        if (sf_ok)
          setup2_r <= pwdata[7:0];
        else
          bad_sf_r <= 1'b1;
      end
      else if (paddr == `SSM_A_TUNING)
        tuning_r <= pwdata[7:0];
      else if (paddr == `SSM_A_THRESH)
        thresh_r <= pwdata[7:0];
      else if (paddr == `SSM_A_FSK_CFG)
        fsk_cfg_r <= pwdata[7:0];
      else if (paddr == `SSM_A_BUF_PTR)
        buf_ptr_r <= pwdata[7:0];
      else if (paddr == `SSM_A_BUF_DATA)
        buf_ptr_r <= buf_ptr_r + 8'h01;
      else if (paddr == `SSM_A_STATUS)
      begin
        // Write one clears the sticky flags
        if (pwdata[0]) bad_sf_r   <= 1'b0;
        if (pwdata[1]) bad_mode_r <= 1'b0;
      end
    end
    else if (rd && hit && paddr == `SSM_A_BUF_DATA)
      buf_ptr_r <= buf_ptr_r + 8'h01;
  end

  // The buffer is written at the pointer and the pointer then steps,
  // so a burst of data writes fills consecutive bytes. The pointer is
  // eight bits wide and wraps at the end of the array.
  // Buffer array write port; second port is the bus read of the data register
  always @(posedge clk_sys)
  begin
    if (wr && hit && paddr == `SSM_A_BUF_DATA)
      buf_mem[buf_ptr_r] <= pwdata[7:0];
  end

  // Read data and the error flag are captured at the setup edge so
  // they stand through the access phase; outside it they read zero.
  // The parameter outputs are registered copies, one cycle behind the
  // registers, so every top-level output comes from a flip-flop.
  // Read data, ready, error and registered outputs
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      spread_mode   <= 1'b0;
      spread_order  <= `SSM_RST_ORDER;
      fec_ratio_sel <= `SSM_RST_CR;
      bw_sel        <= `SSM_RST_BW;
      headerless    <= 1'b0;
      chips_per_sym <= `SSM_RST_CHIPS;
    end
    else
    begin
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~mapped(paddr, spr);
      prdata  <= 32'h00000000;
      if (psel && !penable)
      begin
        if (paddr == `SSM_A_OPMODE)
          prdata <= {24'h000000, op_mode_r};
        else if (paddr == `SSM_A_STATUS)
          prdata <= {29'h0, in_sleep, bad_mode_r, bad_sf_r};
        else if (!spr && paddr == `SSM_A_FSK_CFG)
          prdata <= {24'h000000, fsk_cfg_r};
        else if (spr && paddr == `SSM_A_SETUP1)
          prdata <= {24'h000000, setup1_r};
        else if (spr && paddr == `SSM_A_SETUP2)
          prdata <= {24'h000000, setup2_r};
        else if (spr && paddr == `SSM_A_TUNING)
          prdata <= {24'h000000, tuning_r};
        else if (spr && paddr == `SSM_A_THRESH)
          prdata <= {24'h000000, thresh_r};
        else if (spr && paddr == `SSM_A_BUF_PTR)
          prdata <= {24'h000000, buf_ptr_r};
        else if (spr && paddr == `SSM_A_BUF_DATA)
          prdata <= {24'h000000, buf_mem[buf_ptr_r]};
      end
      // Parameter copies follow the registers every cycle; the chip
      // count is the power of two of the order, so with the bandwidth
      // code it fixes the symbol rate of the link.
      // Lowest order needs headerless mode; software sets it up.
      spread_mode   <= spr;
      spread_order  <= setup2_r[`SSM_SF_MSB:`SSM_SF_LSB];
      fec_ratio_sel <= setup1_r[`SSM_CR_MSB:`SSM_CR_LSB];
      bw_sel        <= setup1_r[`SSM_BW_MSB:`SSM_BW_LSB];
      headerless    <= setup1_r[`SSM_IH_BIT];
      chips_per_sym <= 13'h0001 << setup2_r[`SSM_SF_MSB:`SSM_SF_LSB];
    end
  end

endmodule

// ==== verif/ssm_chk_sva.sv ====
// Port assertions for the spread modem parameter block
`timescale 1ns/100ps
module ssm_chk
(
  input wire        clk_sys,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        spread_mode,
  input wire [3:0]  spread_order,
  input wire [2:0]  fec_ratio_sel,
  input wire [3:0]  bw_sel
);
  wire acc  = psel && penable;          // Access phase, zero wait
  wire w_op = acc && paddr == 12'h000;  // Access to the mode register
  wire w_s1 = acc && paddr == 12'h004;  // Access to setup one
  // Place hidden by the current modem choice
  wire hid  = paddr == (spread_mode ? 12'h018 : 12'h008);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_sf; spread_order inside {[4'h6:4'hC]}; endproperty
  a_sf: assert property (p_sf) else $error("order out of range");
  property p_cr; fec_ratio_sel inside {[3'h1:3'h4]}; endproperty
  a_cr: assert property (p_cr) else $error("ratio out of range");
  property p_bw; bw_sel <= 4'h9; endproperty
  a_bw: assert property (p_bw) else $error("bandwidth code too big");
  property p_rdy; !$past(reset) |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("bus not ready");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  // Outputs follow a taken write two edges later
  property p_mode; $changed(spread_mode) |-> $past(w_op, 2); endproperty
  a_mode: assert property (p_mode) else $error("modem choice moved");
  property p_set; $changed(bw_sel) |-> $past(w_s1, 2); endproperty
  a_set: assert property (p_set) else $error("bandwidth moved");
  property p_map; acc && hid |-> pslverr; endproperty
  a_map: assert property (p_map) else $error("hidden place answered");
endmodule

// ==== verif/ssm_peer.sv ====
// Peer transceiver model: reports whether its spread order matches ours
`timescale 1ns/100ps
module ssm_peer
(
  input  wire [3:0] local_order, // Order in use at this end
  input  wire [3:0] peer_order,  // Order the peer was set up with
  output wire       link_ok      // High when symbols can be recovered
);
  // Orders are orthogonal, so only an exact match links
  assign link_ok = (local_order == peer_order);
endmodule

// ==== verif/testbench.sv ====
// Bench driving APB calls into the spread modem parameter block
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
  logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, spread_mode, headerless, er;
  logic        link_ok;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF, spread_order, bw_sel, peer_order = 4'h6;
  logic [2:0]  fec_ratio_sel;
  logic [12:0] chips_per_sym;
  int          miscompares = 0, num_checks = 0;
  ssm_modem_params dut
  (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .spread_mode, .spread_order,
    .fec_ratio_sel, .bw_sel, .headerless, .chips_per_sym
  );
  ssm_peer peer (.local_order(spread_order), .peer_order, .link_ok);
  initial forever #2.5 clk_sys = ~clk_sys; // 200 MHz
  // Verdict, reached at the end of the run or from a stalled wait
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; pready !== 1'b1 && n < 50; n++)
      @(posedge clk_sys);
    miscompares += int'(n == 50);
    if (n == 50) final_report;
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    repeat (2) @(posedge clk_sys); // Outputs lag the register a cycle
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(0, 12'h008, 0);
    `CHK("hidden setup2", 1'b1, er)
    apb(1, 12'h000, 32'h80);
    `CHK("spread mode", 1'b1, spread_mode)
    // Orders 5 and 13 are refused; 5 also shows the reset order
    for (int o = 5; o < 14; o++)
    begin
      peer_order = o[3:0];
      apb(1, 12'h008, o << 4);
      `CHK("order", o == 5 ? 7 : o > 12 ? 12 : o, spread_order)
      `CHK("peer link", o > 5 && o < 13, link_ok)
      `CHK("chips", 13'h0001 << (o == 5 ? 7 : o > 12 ? 12 : o),
           chips_per_sym)
    end
    // Every bandwidth and ratio code, then a bandwidth past the table
    for (int b = 0; b < 11; b++)
    begin
      apb(1, 12'h004, {b[3:0], 3'(b % 4 + 1), b[0]}); // bandwidth b, ratio b % 4 + 1, headerless b[0]
      `CHK("headerless", b > 9 ? 1 : b[0], headerless)
      `CHK("bandwidth", b > 9 ? 9 : b, bw_sel)
      `CHK("ratio", b > 9 ? 2 : b % 4 + 1, fec_ratio_sel)
    end
    apb(0, 12'h00C, 0);
    `CHK("tuning default", 32'hC3, rd)
    apb(0, 12'h010, 0);
    `CHK("threshold default", 32'h0A, rd)
    // Lowest order: headerless, tuning field 0b101, threshold 0x0C
    apb(1, 12'h008, 32'h60);
    apb(1, 12'h004, 32'h73);
    `CHK("headerless at order 6", 1'b1, headerless)
    `CHK("chips at order 6", 13'h0040, chips_per_sym)
    apb(1, 12'h00C, 32'hC5);
    apb(0, 12'h00C, 0);
    `CHK("tuning order 6", 32'hC5, rd)
    apb(1, 12'h010, 32'h0C);
    apb(0, 12'h010, 0);
    `CHK("threshold order 6", 32'h0C, rd)
    apb(1, 12'h008, 32'h70);
    apb(1, 12'h00C, 32'hC3);
    apb(1, 12'h010, 32'h0A);
    apb(0, 12'h00C, 0);
    `CHK("tuning restored", 32'hC3, rd)
    apb(0, 12'h010, 0);
    `CHK("threshold restored", 32'h0A, rd)
    // Buffer: two bytes in, pointer steps, bytes read back
    apb(1, 12'h01C, 0);
    apb(1, 12'h020, 32'hA5);
    apb(1, 12'h020, 32'h5A);
    apb(0, 12'h01C, 0);
    `CHK("buffer pointer", 32'h02, rd)
    apb(1, 12'h01C, 0);
    apb(0, 12'h020, 0);
    `CHK("buffer byte 0", 32'hA5, rd)
    apb(0, 12'h020, 0);
    `CHK("buffer byte 1", 32'h5A, rd)
    apb(0, 12'h018, 0);
    `CHK("hidden fsk cfg", 1'b1, er)
    apb(0, 12'h014, 0);
    `CHK("status bad order", 32'h5, rd)
    apb(1, 12'h014, 32'h3);
    apb(0, 12'h014, 0);
    `CHK("status cleared", 32'h4, rd)
    apb(1, 12'h000, 32'h81);
    apb(1, 12'h000, 32'h01);
    `CHK("switch out of sleep", 1'b1, spread_mode)
    apb(0, 12'h000, 0);
    `CHK("mode after refusal", 32'h81, rd)
    apb(0, 12'h014, 0);
    `CHK("status refused switch", 32'h2, rd)
    final_report;
  end
endmodule
bind ssm_modem_params ssm_chk chk (.clk_sys, .reset, .psel, .penable,
  .paddr, .pready, .pslverr, .spread_mode, .spread_order, .fec_ratio_sel,
  .bw_sel);
